/* hdl/asl_consts.svh */
/*
 * constants of the converter startup sequencer: register map of the
 * converter configuration port, field positions, reset values, timings.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef ASL_CONSTS_SVH
`define ASL_CONSTS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define ASL_CLK_MHZ          200
`define ASL_SOFT_RST_NS      1000
// least time, rounded up to whole cycles
`define ASL_SOFT_RST_CYC     ((`ASL_SOFT_RST_NS * `ASL_CLK_MHZ + 999) / 1000)
`define ASL_CAL_RUN_CYC      64

// ****************************************************************
// configuration port
// ****************************************************************
`define ASL_ADDR_W           4
`define ASL_DATA_W           8
`define ASL_REG_SOFT_RESET   4'h0
`define ASL_REG_LINK_ENABLE  4'h1
`define ASL_REG_CAL_ENABLE   4'h2
`define ASL_REG_LINK_MODE    4'h3
`define ASL_REG_MULTIFRAME   4'h4
`define ASL_REG_SYNC_SOURCE  4'h5
`define ASL_REG_CAL_CONFIG   4'h6
`define ASL_REG_OVERRANGE    4'h7
`define ASL_REG_CAL_TRIGGER  4'h8

// ****************************************************************
// fields
// ****************************************************************
`define ASL_BIT_ENABLE       0
`define ASL_BIT_CAL_BGND     0
`define ASL_BIT_CAL_OFFSET   1
`define ASL_BIT_OVR_ENABLE   0
`define ASL_OVR_THR_LSB      1
`define ASL_MODE_W           5

// ****************************************************************
// reset values
// ****************************************************************
`define ASL_RST_LINK_ENABLE  1'b1
`define ASL_RST_CAL_ENABLE   1'b1
`define ASL_RST_LINK_MODE    5'h00
`define ASL_RST_MULTIFRAME   8'h1f
`define ASL_RST_SYNC_SOURCE  1'b0
`define ASL_RST_CAL_CONFIG   2'h0
`define ASL_RST_OVERRANGE    8'h00

`endif

/* hdl/asl_pkg.sv */
/*
 * types of the converter startup sequencer.
 * assumes asl_consts.svh for widths.
 */
package asl_pkg;

	// host sequence steps, in order of issue
	typedef enum logic [4:0] {
		HS_IDLE, HS_WAIT_CLK, HS_SOFT_RST, HS_WAIT_RST, HS_LINK_OFF, HS_CAL_OFF,
		HS_MODE, HS_MULTIFRAME, HS_SYNC_SRC, HS_CAL_CFG, HS_CAL_ON, HS_OVR,
		HS_LINK_ON, HS_TRIG_LOW, HS_TRIG_HIGH, HS_DONE
	} asl_host_state_t;

	// link state machine of the converter
	typedef enum logic [1:0] {
		LS_HALTED, LS_CODE_SYNC, LS_DATA
	} asl_link_state_t;

	// calibration state machine of the converter
	typedef enum logic [1:0] {
		CS_HALTED, CS_READY, CS_RUN
	} asl_cal_state_t;

endpackage : asl_pkg

/* hdl/asl_link_if.sv */
/*
 * configuration port and sync signals between host and converter.
 * assumes both ends on core_clk; host drives writes and sync, device status.
 */
`timescale 1ns/1ps
`include "asl_consts.svh"

interface asl_link_if
(
	input wire logic core_clk,
	input wire logic reset
);
	logic                     wrEn;      // one-cycle write strobe
	logic [`ASL_ADDR_W-1:0]   wrAddr;
	logic [`ASL_DATA_W-1:0]   wrData;
	logic                     syncReqN;  // receiver sync request, active low
	logic                     tsSyncN;   // timestamp pair sync, active low
	logic                     rstBusy;   // device internal reset running
	logic [1:0]               linkState;
	logic                     calBusy;

	modport dev
	(
		input  core_clk, reset, wrEn, wrAddr, wrData, syncReqN, tsSyncN,
		output rstBusy, linkState, calBusy
	);

	modport host
	(
		input  core_clk, reset, rstBusy, linkState, calBusy,
		output wrEn, wrAddr, wrData, syncReqN, tsSyncN
	);
endinterface : asl_link_if

/* hdl/asl_sync_bit.sv */
/*
 * two flip-flop synchroniser for one level.
 * assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ps

module asl_sync_bit
#(
	parameter logic RST_VAL = 1'b0
)
(
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic stage1_q;

	// first stage read only by the second
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			stage1_q <= RST_VAL;
			syncOut  <= RST_VAL;
		end
		else
		begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end
endmodule : asl_sync_bit

/* hdl/asl_host_seq.sv */
/*
 * host end: startup sequencer that programs the converter in order,
 * drives the receiver sync lines and sequences the supply regulators.
 * assumes power-good and clock-stable arrive as asynchronous pins and
 * the converter end sits on the same core_clk behind asl_link_if.
 */
// Functional notes
// [R1] stable device clock before any sequence step
// [R2] soft reset, then wait at least 1 us
// [R3] halt link before changing link settings
// [R4] halt calibration before changing its settings
// [R5] write link mode while both halted
// [R6] multiframe field holds frames minus one
// [R7] sync source picks sync pin or timestamp
// [R8] set calibration mode before re-enabling it
// [R9] enable calibration after its settings
// [R10] overrange settings after calibration enable
// [R11] link enable last, restarts link machine
// [R12] link advances on receiver sync request
// [R13] trigger written zero then one starts calibration
// [R14] low rails enabled only after high rail good
// [R15] low rails off at once on high loss; here lowRailsEnable clears three cycles after highRailGoodPin drops
// [R16] one write per step, in listed order
`timescale 1ns/1ps
`include "asl_consts.svh"

module asl_host_seq
	import asl_pkg::*;
#(
	parameter int RST_WAIT_CYC = `ASL_SOFT_RST_CYC
)
(
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	asl_link_if.host                    link,
	input  wire logic                   start,
	input  wire logic [`ASL_MODE_W-1:0] cfgLinkMode,
	input  wire logic [7:0]             cfgFramesPerMulti,
	input  wire logic                   cfgSyncFromTs,
	input  wire logic                   cfgCalBackground,
	input  wire logic                   cfgCalOffset,
	input  wire logic                   cfgOvrEnable,
	input  wire logic [6:0]             cfgOvrThreshold,
	input  wire logic                   rxSyncReqN,
	input  wire logic                   rxTsSyncN,
	input  wire logic                   clkStablePin,
	input  wire logic                   highRailGoodPin,
	output logic                        lowRailsEnable,
	output logic                        seqBusy,
	output logic                        seqDone,
	output logic                        linkUp,
	output logic                        calRunning
);
	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (RST_WAIT_CYC < 1 || RST_WAIT_CYC > 65535)
	begin : gChk
		$error("asl_host_seq: RST_WAIT_CYC out of range");
	end

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic clkStable;
	logic highRailGood;

	asl_sync_bit #(.RST_VAL(1'b0)) uSyncClk
	(
		.core_clk (core_clk),
		.reset    (reset),
		.asyncIn  (clkStablePin),
		.syncOut  (clkStable)
	);

	asl_sync_bit #(.RST_VAL(1'b0)) uSyncPg
	(
		.core_clk (core_clk),
		.reset    (reset),
		.asyncIn  (highRailGoodPin),
		.syncOut  (highRailGood)
	);

	// ****************************************************************
	// supply sequencing
	// ****************************************************************
	// enable follows good high rail; drop clears it in the next cycle
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			lowRailsEnable <= 1'b0;
		else
			lowRailsEnable <= highRailGood; // [R14] [R15]
	end

	// ****************************************************************
	// sequence state machine
	// ****************************************************************
	asl_host_state_t   state_q;
	asl_host_state_t   state_d;
	logic [15:0]       waitCnt_q;
	logic              powerOk;

	assign powerOk = lowRailsEnable & highRailGood;

	// next step; a power loss abandons the sequence
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			HS_IDLE:       if (start && powerOk) state_d = HS_WAIT_CLK;
			HS_WAIT_CLK:   if (clkStable) state_d = HS_SOFT_RST; // [R1]
			HS_SOFT_RST:   state_d = HS_WAIT_RST;
			HS_WAIT_RST:
				if (waitCnt_q == 16'(RST_WAIT_CYC - 1) && !link.rstBusy)
					state_d = HS_LINK_OFF; // [R2]
			HS_LINK_OFF:   state_d = HS_CAL_OFF;
			HS_CAL_OFF:    state_d = HS_MODE;
			HS_MODE:       state_d = HS_MULTIFRAME;
			HS_MULTIFRAME: state_d = HS_SYNC_SRC;
			HS_SYNC_SRC:   state_d = HS_CAL_CFG;
			HS_CAL_CFG:    state_d = HS_CAL_ON;
			HS_CAL_ON:     state_d = HS_OVR;
			HS_OVR:        state_d = HS_LINK_ON;
			HS_LINK_ON:    state_d = HS_TRIG_LOW;
			HS_TRIG_LOW:   state_d = HS_TRIG_HIGH;
			HS_TRIG_HIGH:  state_d = HS_DONE;
			HS_DONE:       if (start && powerOk) state_d = HS_WAIT_CLK;
		endcase
		if (!powerOk && state_q != HS_IDLE)
			state_d = HS_IDLE;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			state_q <= HS_IDLE;
		else
			state_q <= state_d; // [R16]
	end

	// reset wait counter, saturates at the end of the wait
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			waitCnt_q <= 16'h0000;
		else if (state_q != HS_WAIT_RST)
			waitCnt_q <= 16'h0000;
		else if (waitCnt_q != 16'(RST_WAIT_CYC - 1))
			waitCnt_q <= waitCnt_q + 16'h0001; // [R2]
	end

	// ****************************************************************
	// configuration writes, one per step
	// ****************************************************************
	logic                   wrEn_q;
	logic [`ASL_ADDR_W-1:0] wrAddr_q;
	logic [`ASL_DATA_W-1:0] wrData_q;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			wrEn_q   <= 1'b0;
			wrAddr_q <= 4'h0;
			wrData_q <= 8'h00;
		end
		else
		begin
			wrEn_q   <= 1'b1;
			wrData_q <= 8'h00;
			unique case (state_d)
				HS_SOFT_RST:
				begin
					wrAddr_q <= `ASL_REG_SOFT_RESET;
					wrData_q <= 8'h01; // [R2]
				end
				HS_LINK_OFF:
					wrAddr_q <= `ASL_REG_LINK_ENABLE; // [R3]
				HS_CAL_OFF:
					wrAddr_q <= `ASL_REG_CAL_ENABLE; // [R4]
				HS_MODE:
				begin
					wrAddr_q <= `ASL_REG_LINK_MODE;
					wrData_q <= {3'h0, cfgLinkMode}; // [R5]
				end
				HS_MULTIFRAME:
				begin
					wrAddr_q <= `ASL_REG_MULTIFRAME;
					wrData_q <= cfgFramesPerMulti - 8'h01; // [R6]
				end
				HS_SYNC_SRC:
				begin
					wrAddr_q <= `ASL_REG_SYNC_SOURCE;
					wrData_q <= {7'h00, cfgSyncFromTs}; // [R7]
				end
				HS_CAL_CFG:
				begin
					wrAddr_q <= `ASL_REG_CAL_CONFIG;
					wrData_q <= {6'h00, cfgCalOffset, cfgCalBackground}; // [R8]
				end
				HS_CAL_ON:
				begin
					wrAddr_q <= `ASL_REG_CAL_ENABLE;
					wrData_q <= 8'h01; // [R9]
				end
				HS_OVR:
				begin
					wrAddr_q <= `ASL_REG_OVERRANGE;
					wrData_q <= {cfgOvrThreshold, cfgOvrEnable}; // [R10]
				end
				HS_LINK_ON:
				begin
					wrAddr_q <= `ASL_REG_LINK_ENABLE;
					wrData_q <= 8'h01; // [R11]
				end
				HS_TRIG_LOW:
					wrAddr_q <= `ASL_REG_CAL_TRIGGER; // [R13]
				HS_TRIG_HIGH:
				begin
					wrAddr_q <= `ASL_REG_CAL_TRIGGER;
					wrData_q <= 8'h01; // [R13]
				end
				default:
					wrEn_q <= 1'b0; // waiting steps issue nothing
			endcase
			if (state_d == state_q)
				wrEn_q <= 1'b0; // a held step never repeats its write
		end
	end

	assign link.wrEn   = wrEn_q;
	assign link.wrAddr = wrAddr_q;
	assign link.wrData = wrData_q;

	// ****************************************************************
	// receiver sync and status
	// ****************************************************************
	logic syncReqN_q;
	logic tsSyncN_q;

	// receiver logic drives sync, registered toward the converter
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			syncReqN_q <= 1'b0;
			tsSyncN_q  <= 1'b0;
		end
		else
		begin
			syncReqN_q <= rxSyncReqN; // [R12]
			tsSyncN_q  <= rxTsSyncN;
		end
	end

	assign link.syncReqN = syncReqN_q;
	assign link.tsSyncN  = tsSyncN_q;

	// status outputs from flops
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			seqBusy    <= 1'b0;
			seqDone    <= 1'b0;
			linkUp     <= 1'b0;
			calRunning <= 1'b0;
		end
		else
		begin
			seqBusy    <= (state_d != HS_IDLE) && (state_d != HS_DONE);
			seqDone    <= (state_d == HS_DONE);
			linkUp     <= (link.linkState == 2'(LS_DATA));
			calRunning <= link.calBusy;
		end
	end
endmodule : asl_host_seq

/* hdl/asl_dev_cfg.sv */
/*
 * converter end: configuration registers, soft reset, link and
 * calibration state machines, driven through asl_link_if.
 * assumes host writes and sync lines come from logic on core_clk.
 */
`timescale 1ns/1ps
`include "asl_consts.svh"

module asl_dev_cfg
	import asl_pkg::*;
#(
	parameter int RST_CYC = `ASL_SOFT_RST_CYC,
	parameter int CAL_CYC = `ASL_CAL_RUN_CYC
)
(
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	asl_link_if.dev                     link,
	output logic [`ASL_MODE_W-1:0]      linkModeOut,
	output logic [7:0]                  multiframeOut,
	output logic                        syncFromTsOut,
	output logic [1:0]                  calConfigOut,
	output logic [7:0]                  overrangeOut,
	output logic                        calDoneStrobe
);
	if (RST_CYC < 1 || RST_CYC > 65535 || CAL_CYC < 1 || CAL_CYC > 65535)
	begin : gChk
		$error("asl_dev_cfg: cycle counts out of range");
	end

	// ****************************************************************
	// soft reset
	// ****************************************************************
	logic [15:0] rstCnt_q;
	logic        rstBusy_q;
	logic        wr;

	assign wr = link.wrEn & ~rstBusy_q; // writes during reset are dropped

	// internal reset completes within the host wait
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rstBusy_q <= 1'b0;
			rstCnt_q  <= 16'h0000;
		end
		else if (wr && link.wrAddr == `ASL_REG_SOFT_RESET && link.wrData[`ASL_BIT_ENABLE])
		begin
			rstBusy_q <= 1'b1;
			rstCnt_q  <= 16'(RST_CYC - 1);
		end
		else if (rstCnt_q != 16'h0000)
			rstCnt_q <= rstCnt_q - 16'h0001; // [R2]
		else
			rstBusy_q <= 1'b0;
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic linkEn_q;
	logic calEn_q;
	logic calTrig_q;

	// link and cal settings take writes only while their enable is clear; overrange takes them at any time
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			linkEn_q      <= `ASL_RST_LINK_ENABLE;
			calEn_q       <= `ASL_RST_CAL_ENABLE;
			calTrig_q     <= 1'b0;
			linkModeOut   <= `ASL_RST_LINK_MODE;
			multiframeOut <= `ASL_RST_MULTIFRAME;
			syncFromTsOut <= `ASL_RST_SYNC_SOURCE;
			calConfigOut  <= `ASL_RST_CAL_CONFIG;
			overrangeOut  <= `ASL_RST_OVERRANGE;
		end
		else if (rstBusy_q)
		begin
			// soft reset restores the same values, synchronously
			linkEn_q      <= `ASL_RST_LINK_ENABLE; // [R2]
			calEn_q       <= `ASL_RST_CAL_ENABLE;
			calTrig_q     <= 1'b0;
			linkModeOut   <= `ASL_RST_LINK_MODE;
			multiframeOut <= `ASL_RST_MULTIFRAME;
			syncFromTsOut <= `ASL_RST_SYNC_SOURCE;
			calConfigOut  <= `ASL_RST_CAL_CONFIG;
			overrangeOut  <= `ASL_RST_OVERRANGE;
		end
		else if (wr)
		begin
			unique case (link.wrAddr)
				`ASL_REG_LINK_ENABLE: linkEn_q <= link.wrData[`ASL_BIT_ENABLE]; // [R3] [R11]
				`ASL_REG_CAL_ENABLE:  calEn_q <= link.wrData[`ASL_BIT_ENABLE]; // [R4] [R9]
				`ASL_REG_CAL_TRIGGER: calTrig_q <= link.wrData[`ASL_BIT_ENABLE];
				`ASL_REG_LINK_MODE:
					if (!linkEn_q) linkModeOut <= link.wrData[`ASL_MODE_W-1:0]; // [R3]
				`ASL_REG_MULTIFRAME:
					if (!linkEn_q) multiframeOut <= link.wrData; // [R3]
				`ASL_REG_SYNC_SOURCE:
					if (!linkEn_q) syncFromTsOut <= link.wrData[`ASL_BIT_ENABLE]; // [R7]
				`ASL_REG_CAL_CONFIG:
					if (!calEn_q) calConfigOut <= link.wrData[1:0]; // [R4]
				`ASL_REG_OVERRANGE:   overrangeOut <= link.wrData;
				default:              ;
			endcase
		end
	end

	// ****************************************************************
	// link state machine
	// ****************************************************************
	asl_link_state_t linkState_q;
	logic            syncN;

	assign syncN = syncFromTsOut ? link.tsSyncN : link.syncReqN; // [R7]

	// sync request low holds code sync; release enters data
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			linkState_q <= LS_HALTED;
		else if (!linkEn_q || rstBusy_q)
			linkState_q <= LS_HALTED; // [R3]
		else if (!syncN)
			linkState_q <= LS_CODE_SYNC; // [R12]
		else if (linkState_q == LS_CODE_SYNC)
			linkState_q <= LS_DATA; // [R12]
	end

	// ****************************************************************
	// calibration state machine
	// ****************************************************************
	asl_cal_state_t calState_q;
	logic [15:0]    calCnt_q;
	logic           trigRise;

	assign trigRise = wr && link.wrAddr == `ASL_REG_CAL_TRIGGER
		&& link.wrData[`ASL_BIT_ENABLE] && !calTrig_q; // [R13]

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			calState_q    <= CS_HALTED;
			calCnt_q      <= 16'h0000;
			calDoneStrobe <= 1'b0;
		end
		else
		begin
			calDoneStrobe <= 1'b0;
			if (!calEn_q || rstBusy_q)
				calState_q <= CS_HALTED; // [R4]
			else
			begin
				unique case (calState_q)
					CS_HALTED: calState_q <= CS_READY; // [R9]
					CS_READY:
						if (trigRise)
						begin
							calState_q <= CS_RUN; // [R13]
							calCnt_q   <= 16'(CAL_CYC - 1);
						end
					CS_RUN:
						if (calCnt_q == 16'h0000)
						begin
							calState_q    <= CS_READY;
							calDoneStrobe <= 1'b1;
						end
						else
							calCnt_q <= calCnt_q - 16'h0001;
				endcase
			end
		end
	end

	assign link.rstBusy   = rstBusy_q;
	assign link.linkState = linkState_q;
	assign link.calBusy   = (calState_q == CS_RUN);
endmodule : asl_dev_cfg

/* bench/asl_link_props.sv */
/*
 * checker for the host to converter configuration link.
 * assumes one core_clk domain, reset active high, instantiated beside asl_link_if.
 */
`timescale 1ns/1ps
`include "asl_consts.svh"

module asl_link_props
	import asl_pkg::*;
#(
	parameter int RST_CYC = `ASL_SOFT_RST_CYC,
	parameter int CAL_CYC = `ASL_CAL_RUN_CYC
)
(
	input wire logic                   core_clk,
	input wire logic                   reset,
	input wire logic                   wrEn,
	input wire logic [`ASL_ADDR_W-1:0] wrAddr,
	input wire logic [`ASL_DATA_W-1:0] wrData,
	input wire logic                   syncReqN,
	input wire logic                   tsSyncN,
	input wire logic                   rstBusy,
	input wire logic [1:0]             linkState,
	input wire logic                   calBusy
);
	// ****************************************************************
	// helper logic
	// ****************************************************************
	logic [15:0] busyCnt_q;
	logic [16:0] calCnt_q;
	logic        calOffWr;

	// cal halt write, seen four cycles before cal settings
	assign calOffWr = wrEn && wrAddr == `ASL_REG_CAL_ENABLE && !wrData[0];

	// length of the soft reset window
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			busyCnt_q <= 16'h0000;
		else if (rstBusy)
			busyCnt_q <= busyCnt_q + 16'h0001;
		else
			busyCnt_q <= 16'h0000;

	// length of a calibration run
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			calCnt_q <= 17'h00000;
		else if (calBusy)
			calCnt_q <= calCnt_q + 17'h00001;
		else
			calCnt_q <= 17'h00000;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	soft_reset_start_a: assert property (
		wrEn && wrAddr == `ASL_REG_SOFT_RESET && wrData[0] && !rstBusy |=> rstBusy)
		else $error("soft reset write did not start the reset window");
	soft_reset_len_a: assert property (
		$fell(rstBusy) |-> busyCnt_q == RST_CYC)
		else $error("soft reset window has wrong length");
	reset_quiet_a: assert property (
		wrEn && wrAddr == `ASL_REG_SOFT_RESET && wrData[0] |=> !wrEn [*4])
		else $error("write issued too soon after soft reset");
	busy_no_write_a: assert property (
		rstBusy |-> !wrEn)
		else $error("write issued during soft reset");
	link_halt_a: assert property (
		wrEn && wrAddr == `ASL_REG_LINK_ENABLE && !wrData[0] && !rstBusy |=> ##1 linkState == 2'h0)
		else $error("link not halted after enable cleared");
	mode_halted_a: assert property (
		wrEn && wrAddr == `ASL_REG_LINK_MODE |-> linkState == 2'h0 && !calBusy)
		else $error("link mode written while machines run");
	cal_halt_first_a: assert property (
		wrEn && wrAddr == `ASL_REG_CAL_CONFIG |-> $past(calOffWr, 4))
		else $error("cal settings written without halting cal");
	cfg_order_a: assert property (
		wrEn && wrAddr == `ASL_REG_LINK_MODE |=> (wrEn && wrAddr == `ASL_REG_MULTIFRAME)
		##1 (wrEn && wrAddr == `ASL_REG_SYNC_SOURCE) ##1 (wrEn && wrAddr == `ASL_REG_CAL_CONFIG)
		##1 (wrEn && wrAddr == `ASL_REG_CAL_ENABLE && wrData[0]))
		else $error("configuration writes out of order");
	link_last_a: assert property (
		wrEn && wrAddr == `ASL_REG_CAL_ENABLE && wrData[0] |=> (wrEn && wrAddr == `ASL_REG_OVERRANGE)
		##1 (wrEn && wrAddr == `ASL_REG_LINK_ENABLE && wrData[0]))
		else $error("link enable not last after overrange");
	trigger_edge_a: assert property (
		wrEn && wrAddr == `ASL_REG_LINK_ENABLE && wrData[0] |=>
		(wrEn && wrAddr == `ASL_REG_CAL_TRIGGER && wrData == 8'h00)
		##1 (wrEn && wrAddr == `ASL_REG_CAL_TRIGGER && wrData[0]) ##[1:2] calBusy)
		else $error("trigger zero then one did not start calibration");
	sync_to_data_a: assert property (
		linkState == 2'h1 && syncReqN && tsSyncN && !wrEn && !rstBusy |-> ##[1:2] linkState == 2'h2)
		else $error("link did not reach data after sync release");
	no_skip_a: assert property (
		linkState == 2'h0 |=> linkState != 2'h2)
		else $error("link jumped from halted to data");
	cal_len_a: assert property (
		$fell(calBusy) |-> calCnt_q >= CAL_CYC && calCnt_q <= CAL_CYC + 1)
		else $error("calibration run has wrong length");
endmodule : asl_link_props

/* bench/testbench.sv */
/*
 * self-checking bench: host sequencer and converter end joined by asl_link_if.
 * assumes asl_pkg, asl_consts.svh and all design files compiled before.
 */
`timescale 1ns/1ps
`include "asl_consts.svh"

module testbench;
	// ****************************************************************
	// signals and instances
	// ****************************************************************
	localparam int RST_N = 4;
	localparam int CAL_N = 8;

	logic       core_clk = 1'b0, reset = 1'b1, start = 1'b0;
	logic [4:0] cfgLinkMode = 5'h00;
	logic [7:0] cfgFramesPerMulti = 8'h20;
	logic       cfgSyncFromTs = 1'b0, cfgCalBackground = 1'b0, cfgCalOffset = 1'b0;
	logic       cfgOvrEnable = 1'b0;
	logic [6:0] cfgOvrThreshold = 7'h00;
	logic       rxSyncReqN = 1'b1, rxTsSyncN = 1'b1;
	logic       clkStablePin = 1'b0, highRailGoodPin = 1'b0;
	logic       lowRailsEnable, seqBusy, seqDone, linkUp, calRunning, syncFromTsOut, calDoneStrobe;
	logic [4:0] linkModeOut;
	logic [7:0] multiframeOut, overrangeOut;
	logic [1:0] calConfigOut;
	int         numErrors = 0, samplesChecked = 0, wrCount = 0, calDones = 0;

	always #2.5 core_clk = ~core_clk;

	asl_link_if lnk (.core_clk(core_clk), .reset(reset));

	asl_host_seq #(.RST_WAIT_CYC(RST_N)) i_asl_host_seq (
		.core_clk(core_clk), .reset(reset), .link(lnk), .start(start),
		.cfgLinkMode(cfgLinkMode), .cfgFramesPerMulti(cfgFramesPerMulti),
		.cfgSyncFromTs(cfgSyncFromTs), .cfgCalBackground(cfgCalBackground),
		.cfgCalOffset(cfgCalOffset), .cfgOvrEnable(cfgOvrEnable),
		.cfgOvrThreshold(cfgOvrThreshold), .rxSyncReqN(rxSyncReqN), .rxTsSyncN(rxTsSyncN),
		.clkStablePin(clkStablePin), .highRailGoodPin(highRailGoodPin),
		.lowRailsEnable(lowRailsEnable), .seqBusy(seqBusy), .seqDone(seqDone),
		.linkUp(linkUp), .calRunning(calRunning));

	asl_dev_cfg #(.RST_CYC(RST_N), .CAL_CYC(CAL_N)) i_asl_dev_cfg (
		.core_clk(core_clk), .reset(reset), .link(lnk), .linkModeOut(linkModeOut),
		.multiframeOut(multiframeOut), .syncFromTsOut(syncFromTsOut),
		.calConfigOut(calConfigOut), .overrangeOut(overrangeOut),
		.calDoneStrobe(calDoneStrobe));

	asl_link_props #(.RST_CYC(RST_N), .CAL_CYC(CAL_N)) i_asl_link_props (
		.core_clk(core_clk), .reset(reset), .wrEn(lnk.wrEn), .wrAddr(lnk.wrAddr),
		.wrData(lnk.wrData), .syncReqN(lnk.syncReqN), .tsSyncN(lnk.tsSyncN),
		.rstBusy(lnk.rstBusy), .linkState(lnk.linkState), .calBusy(lnk.calBusy));

	// counts writes and calibration ends, away from the active edge
	always @(negedge core_clk)
	begin
		if (lnk.wrEn === 1'b1) wrCount++;
		if (calDoneStrobe === 1'b1) calDones++;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic complete_run();
		if (numErrors == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			numErrors++;
		end
	endtask : check

	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cycles

	task automatic pulse_start();
		@(posedge core_clk) start <= 1'b1;
		@(posedge core_clk) start <= 1'b0;
	endtask : pulse_start

	// bounded wait for sequence end or a link state
	task automatic wait_for(input bit forLink, input logic [1:0] st);
		for (int i = 0; i < 400; i++)
		begin
			cycles(1);
			if (!forLink && seqDone === 1'b1) return;
			if (forLink && lnk.linkState === st) return;
		end
		$display("[ERR] t=%0t got=%h exp=%h", $time, lnk.linkState, st);
		numErrors++;
		complete_run();
	endtask : wait_for

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_power_up();
		pulse_start();
		cycles(5);
		check(seqBusy, 1'b0);
		@(posedge core_clk) highRailGoodPin <= 1'b1;
		#1;
		check(lowRailsEnable, 1'b0);
		cycles(4);
		check(lowRailsEnable, 1'b1);
	endtask : t_power_up

	task automatic t_run(input logic [4:0] mode, input logic [7:0] k, input logic ts,
		input logic bg, input logic off, input logic oen, input logic [6:0] thr);
		int base;
		int cd;
		@(posedge core_clk);
		cfgLinkMode <= mode;
		cfgFramesPerMulti <= k;
		cfgSyncFromTs <= ts;
		{cfgCalOffset, cfgCalBackground} <= {off, bg};
		{cfgOvrThreshold, cfgOvrEnable} <= {thr, oen};
		base = wrCount;
		cd = calDones;
		pulse_start();
		if (clkStablePin !== 1'b1)
		begin
			cycles(12);
			check(wrCount - base, 0);
			check(seqBusy, 1'b1);
			@(posedge core_clk) clkStablePin <= 1'b1;
		end
		wait_for(1'b0, 2'h0);
		check(linkModeOut, mode);
		check(multiframeOut, k - 8'h01);
		check(syncFromTsOut, ts);
		check(calConfigOut, {off, bg});
		check(overrangeOut, {thr, oen});
		check(wrCount - base, 12);
		cycles(2);
		check(calRunning, 1'b1);
		cycles(CAL_N + 10);
		check(calRunning, 1'b0);
		check(calDones - cd, 1);
		@(posedge core_clk) {rxTsSyncN, rxSyncReqN} <= ts ? 2'b01 : 2'b10;
		wait_for(1'b1, 2'h1);
		@(posedge core_clk) {rxTsSyncN, rxSyncReqN} <= 2'b11;
		wait_for(1'b1, 2'h2);
		cycles(1);
		check(linkUp, 1'b1);
		@(posedge core_clk) {rxTsSyncN, rxSyncReqN} <= ts ? 2'b10 : 2'b01;
		cycles(5);
		check(lnk.linkState, 2'h2);
		@(posedge core_clk) {rxTsSyncN, rxSyncReqN} <= 2'b11;
	endtask : t_run

	// power loss lands in the soft reset wait, not inside the write chain
	task automatic t_abort();
		pulse_start();
		cycles(1);
		@(posedge core_clk) highRailGoodPin <= 1'b0;
		cycles(4);
		check(lowRailsEnable, 1'b0);
		cycles(3);
		check(seqBusy, 1'b0);
		@(posedge core_clk) highRailGoodPin <= 1'b1;
		cycles(5);
		check(lowRailsEnable, 1'b1);
	endtask : t_abort

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		t_power_up();
		t_run(5'h01, 8'h10, 1'b0, 1'b0, 1'b1, 1'b1, 7'h55);
		t_run(5'h1e, 8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 7'h7f);
		t_abort();
		complete_run();
	end
endmodule : testbench
